// ### core/fsps_pkg.sv
package fsps_pkg;
   // ****************************************
   // APB register map of the controller
   // ****************************************
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_ADDR = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_ERR_BIT = 1;
   localparam int ST_REFUSED_BIT = 2;
   localparam int ST_ERASED_BIT = 3;
   localparam int ST_COUNT_LSB = 4;
   localparam logic [1:0] CMD_ERASE = 2'h1;
   localparam logic [1:0] CMD_LOAD = 2'h2;
   localparam logic [1:0] CMD_ROW = 2'h3;

   // ****************************************
   // Device control values and keys
   // ****************************************
   localparam logic [15:0] CTRL_PAGE_ERASE = 16'h4042;
   localparam logic [15:0] CTRL_ROW_PROG = 16'h4001;
   localparam logic [15:0] CTRL_START = 16'h8000;
   localparam int CTRL_START_BIT = 15;
   localparam int CTRL_ERR_BIT = 13;
   localparam logic [15:0] KEY_FIRST = 16'h0055;
   localparam logic [15:0] KEY_SECOND = 16'h00AA;

   // ****************************************
   // Program memory geometry in instructions and address units
   // ****************************************
   localparam int ROW_INSTR = 64;
   localparam logic [23:0] ADDR_STEP = 24'h000002;
   localparam int ROW_LSB = 7;
   localparam int PAGE_LSB = 10;

   // ****************************************
   // Step list and device operations
   // ****************************************
   localparam logic [3:0] STEP_LOAD_END = 4'h4;
   localparam logic [3:0] STEP_KEY1 = 4'h4;
   localparam logic [3:0] STEP_NOP2 = 4'h8;
   localparam logic [3:0] STEP_POLL = 4'h9;

   typedef enum logic [2:0] {
      OP_NONE, OP_WR_CTRL, OP_WR_PAGE, OP_TBL_LOW, OP_TBL_HIGH, OP_KEY, OP_NOP, OP_RD_CTRL
   } fsps_op_t;

   typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT} fsps_state_t;
endpackage

// ### core/fsps_host.sv
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
// Function
// - Program a row only after erasing the whole eight-row page holding it.
// - Page erase uses operation code 0010 with erase select and write enable set.
// - Write key 0x55 then 0xAA before setting the start bit.
// - Row program uses code 0001, erase select clear, write enable set.
// - Fill holding buffers with 64 instructions, low word then high byte each.
// - Repeat load and program per 64-instruction group, advancing the pointer.
// - Two no-operation cycles follow the instruction that sets start.
// - Hold off interrupts over the five unlock, start and pause instructions.
// - Page erase setup writes 0x4042 to the control register.
// - Row program setup writes 0x4001 to the control register.
module fsps_host #(
   parameter int ROW_WORDS = fsps_pkg::ROW_INSTR
) (
   // Clock, reset and enable
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Device instruction port
   output logic dev_req,
   output fsps_pkg::fsps_op_t dev_op,
   output logic [15:0] dev_ea,
   output logic [15:0] dev_wdata,
   input wire logic dev_ack,
   input wire logic [15:0] dev_rdata,
   // Interrupt hold-off towards the core
   output logic interrupt_hold_off
);
   import fsps_pkg::*;

   // ****************************************
   // Parameter check
   // ****************************************
   generate
      // Buffer holds one row of 64 at most; the seven-bit count covers that
      if (ROW_WORDS < 1 || ROW_WORDS > 64) begin : g_bad_row
         $error("ROW_WORDS must lie in 1..64");
      end
   endgenerate

   localparam logic [6:0] ROW_FULL = 7'(ROW_WORDS);

   typedef struct packed {
      fsps_state_t st;
      logic [1:0] cmd;
      logic [3:0] step;
      logic req;
      fsps_op_t op;
      logic [15:0] ea;
      logic [15:0] wd;
      logic [23:0] addr;
      logic [23:0] data;
      logic [23:0] row_base;
      logic [6:0] count;
      logic [13:0] erased_page;
      logic erased_ok;
      logic seq_err;
      logic refused;
      logic hold_off;
      logic rdy;
      logic err;
      logic [31:0] rdat;
   } fsps_regs_t;

   fsps_regs_t s;
   fsps_regs_t next_s;

   // ****************************************
   // Helper functions
   // ****************************************
   // Operation issued at a step; OP_NONE steps are skipped
   function automatic fsps_op_t step_op(input logic [1:0] cmd, input logic [3:0] step);
      fsps_op_t r;
      r = OP_NONE;
      unique case (step)
         4'h0: r = (cmd == CMD_LOAD) ? OP_NONE : OP_WR_CTRL;
         4'h1: r = OP_WR_PAGE;
         4'h2: r = (cmd == CMD_ROW) ? OP_NONE : OP_TBL_LOW;
         4'h3: r = (cmd == CMD_LOAD) ? OP_TBL_HIGH : OP_NONE;
         4'h4, 4'h5: r = OP_KEY;
         4'h6: r = OP_WR_CTRL;
         4'h7, 4'h8: r = OP_NOP;
         4'h9: r = OP_RD_CTRL;
         default: r = OP_NONE;
      endcase
      return r;
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      return a == OFS_CMD || a == OFS_ADDR || a == OFS_DATA || a == OFS_STATUS;
   endfunction

   // ****************************************
   // Next-state logic
   // ****************************************
   logic apb_wr;
   logic [23:0] target;
   logic [15:0] ctrl_val;
   fsps_op_t op_now;

   // Target address and control word for the running command
   always_comb begin
      unique case (s.cmd)
         CMD_ERASE: target = {s.addr[23:PAGE_LSB], 10'h000};
         CMD_ROW: target = s.row_base;
         default: target = s.addr;
      endcase
      ctrl_val = (s.cmd == CMD_ERASE) ? CTRL_PAGE_ERASE : CTRL_ROW_PROG;
      op_now = step_op(s.cmd, s.step);
   end

   assign apb_wr = psel && penable && s.rdy && pwrite && !s.err;

   always_comb begin
      next_s = s;
      // Registered answer: one wait cycle in every access phase
      if (psel && penable && !s.rdy) begin
         next_s.rdy = 1'b1;
         next_s.err = !is_mapped(paddr);
         next_s.rdat = 32'h00000000;
         unique case (paddr)
            OFS_ADDR: next_s.rdat = {8'h00, s.addr};
            OFS_DATA: next_s.rdat = {8'h00, s.data};
            OFS_STATUS: begin
               next_s.rdat[ST_BUSY_BIT] = s.st != ST_IDLE;
               next_s.rdat[ST_ERR_BIT] = s.seq_err;
               next_s.rdat[ST_REFUSED_BIT] = s.refused;
               next_s.rdat[ST_ERASED_BIT] = s.erased_ok;
               next_s.rdat[ST_COUNT_LSB +: 7] = s.count;
            end
            default: next_s.rdat = 32'h00000000;
         endcase
      end else begin
         next_s.rdy = 1'b0;
         next_s.err = 1'b0;
      end

      // Write-one-to-clear; a set later in this process wins
      if (apb_wr && paddr == OFS_STATUS) begin
         if (pwdata[ST_ERR_BIT]) begin
            next_s.seq_err = 1'b0;
         end
         if (pwdata[ST_REFUSED_BIT]) begin
            next_s.refused = 1'b0;
         end
      end

      // Orders from software, taken only while idle
      if (apb_wr && paddr != OFS_STATUS) begin
         if (s.st != ST_IDLE) begin
            next_s.refused = 1'b1;
         end else if (paddr == OFS_ADDR) begin
            next_s.addr = pwdata[23:0];
         end else if (paddr == OFS_DATA) begin
            next_s.data = pwdata[23:0];
         end else if (pwdata[1:0] == CMD_ERASE) begin
            next_s.cmd = CMD_ERASE;
            next_s.step = 4'h0;
            next_s.st = ST_ISSUE;
         end else if (pwdata[1:0] == CMD_LOAD) begin
            // A group starts on a row boundary and holds one row at most
            if (s.count == ROW_FULL || (s.count == 7'h00 && s.addr[ROW_LSB-1:0] != 7'h00)) begin
               next_s.refused = 1'b1;
            end else begin
               if (s.count == 7'h00) begin
                  next_s.row_base = s.addr;
               end
               next_s.cmd = CMD_LOAD;
               next_s.step = 4'h1;
               next_s.st = ST_ISSUE;
            end
         end else if (pwdata[1:0] == CMD_ROW) begin
            // Only a full buffer into a freshly erased page
            if (s.count != ROW_FULL || !s.erased_ok
                || s.erased_page != s.row_base[23:PAGE_LSB]) begin
               next_s.refused = 1'b1;
            end else begin
               next_s.cmd = CMD_ROW;
               next_s.step = 4'h0;
               next_s.st = ST_ISSUE;
            end
         end else begin
            // Reserved command codes start nothing, they only flag the refusal
            next_s.refused = 1'b1;
         end
      end

      // Instruction sequencer towards the device
      unique case (s.st)
         ST_IDLE: begin
         end
         ST_ISSUE: begin
            if (s.cmd == CMD_LOAD && s.step == STEP_LOAD_END) begin
               // Pointer advance lets software stream the next group
               next_s.addr = s.addr + ADDR_STEP;
               next_s.count = s.count + 7'h01;
               next_s.st = ST_IDLE;
            end else if (op_now == OP_NONE) begin
               next_s.step = s.step + 4'h1;
            end else begin
               next_s.req = 1'b1;
               next_s.op = op_now;
               next_s.ea = target[15:0];
               next_s.wd = 16'h0000;
               unique case (s.step)
                  4'h0: next_s.wd = ctrl_val;
                  4'h1: next_s.wd = {8'h00, target[23:16]};
                  4'h2: next_s.wd = (s.cmd == CMD_ERASE) ? 16'h0000 : s.data[15:0];
                  4'h3: next_s.wd = {8'h00, s.data[23:16]};
                  4'h4: next_s.wd = KEY_FIRST;
                  4'h5: next_s.wd = KEY_SECOND;
                  4'h6: next_s.wd = ctrl_val | CTRL_START;
                  default: next_s.wd = 16'h0000;
               endcase
               next_s.st = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (dev_ack) begin
               next_s.req = 1'b0;
               next_s.st = ST_ISSUE;
               if (s.step != STEP_POLL) begin
                  next_s.step = s.step + 4'h1;
               end else begin
                  // Device reports a refused or broken sequence here
                  if (dev_rdata[CTRL_ERR_BIT]) begin
                     next_s.seq_err = 1'b1;
                  end
                  // Start bit still set: cycle running, read again
                  if (!dev_rdata[CTRL_START_BIT]) begin
                     next_s.st = ST_IDLE;
                     next_s.count = 7'h00;
                     if (s.cmd == CMD_ERASE) begin
                        next_s.erased_page = s.addr[23:PAGE_LSB];
                        next_s.erased_ok = !dev_rdata[CTRL_ERR_BIT];
                     end
                  end
               end
            end
         end
      endcase

      // Hold-off spans both keys, start and the two pauses
      next_s.hold_off = next_s.st != ST_IDLE && next_s.cmd != CMD_LOAD
                        && next_s.step >= STEP_KEY1 && next_s.step <= STEP_NOP2;
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s <= '0;
         s.st <= ST_IDLE;
         s.op <= OP_NONE;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign prdata = s.rdat;
   assign pready = s.rdy;
   assign pslverr = s.err;
   assign dev_req = s.req;
   assign dev_op = s.op;
   assign dev_ea = s.ea;
   assign dev_wdata = s.wd;
   assign interrupt_hold_off = s.hold_off;

   // ****************************************
   // Assertions
   // ****************************************
   // Last instruction the device accepted
   fsps_op_t last_op;
   logic [15:0] last_wd;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         last_op <= OP_NONE;
         last_wd <= 16'h0000;
      end else if (clk_en && s.req && dev_ack) begin
         last_op <= s.op;
         last_wd <= s.wd;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_req_held: assert property (s.req && !(dev_ack && clk_en) |=> s.req && $stable(s.op) && $stable(s.wd)
                                && $stable(s.ea)) else $error("request dropped or changed before ack");
   a_key_order: assert property ($rose(s.req) && s.op == OP_KEY && s.wd == KEY_SECOND
                                 |-> last_op == OP_KEY && last_wd == KEY_FIRST)
                                 else $error("second key out of order");
   a_start_unlock: assert property ($rose(s.req) && s.op == OP_WR_CTRL && s.wd[CTRL_START_BIT]
                                    |-> last_op == OP_KEY && last_wd == KEY_SECOND)
                                    else $error("start without unlock");
   a_nop_follows: assert property ($rose(s.req) && s.op == OP_NOP && last_op == OP_WR_CTRL
                                   |-> last_wd[CTRL_START_BIT]) else $error("pause not after start");
   a_hold_keys: assert property (s.req && (s.op == OP_KEY || s.op == OP_NOP) |-> s.hold_off)
                                 else $error("interrupts not held off");
   a_erase_ctrl: assert property (s.req && s.op == OP_WR_CTRL && s.cmd == CMD_ERASE
                                  |-> s.wd[14:0] == CTRL_PAGE_ERASE[14:0]) else $error("bad erase setup");
   a_row_ctrl: assert property (s.req && s.op == OP_WR_CTRL && s.cmd == CMD_ROW
                                |-> s.wd[14:0] == CTRL_ROW_PROG[14:0]) else $error("bad row setup");
   a_row_gated: assert property (s.st == ST_IDLE && next_s.st != ST_IDLE && next_s.cmd == CMD_ROW && clk_en
                                 |-> s.count == ROW_FULL && s.erased_ok) else $error("row program not gated");
   a_load_align: assert property ($rose(s.req) && s.op == OP_TBL_LOW && s.cmd == CMD_LOAD
                                  && s.count == 7'h00 |-> s.row_base[ROW_LSB-1:0] == 7'h00)
                                  else $error("group not row aligned");
   a_err_seen: assert property (s.req && s.op == OP_RD_CTRL && dev_ack && dev_rdata[CTRL_ERR_BIT] && clk_en
                                |=> s.seq_err) else $error("sequence error lost");
   a_apb_pulse: assert property (s.rdy && clk_en |=> !s.rdy) else $error("pready longer than one cycle");
   // Only codes whose erase select matches are sent, so no write is a silent no-op
   a_ctrl_code: assert property (s.req && s.op == OP_WR_CTRL
                                 |-> s.wd[3:0] == (s.wd[6] ? 4'h2 : 4'h1))
                                 else $error("control code and erase select disagree");
   a_erase_dummy: assert property (s.req && s.op == OP_TBL_LOW && s.cmd == CMD_ERASE
                                   |-> s.ea[PAGE_LSB-1:0] == 10'h000 && s.wd == 16'h0000)
                                   else $error("dummy write not at page base");
   a_poll_end: assert property (s.st == ST_WAIT && s.step == STEP_POLL && dev_ack && clk_en
                                && !dev_rdata[CTRL_START_BIT] |=> s.st == ST_IDLE)
                                else $error("finished cycle not seen");
   a_hold_idle: assert property (s.st == ST_IDLE |-> !s.hold_off) else $error("hold-off outside a sequence");
   a_err_ready: assert property (s.err |-> s.rdy) else $error("slave error without ready");

   c_erase_done: cover property (s.cmd == CMD_ERASE && s.st == ST_WAIT && s.step == STEP_POLL ##1 s.st == ST_IDLE);
   c_row_done: cover property (s.cmd == CMD_ROW && s.st == ST_WAIT && s.step == STEP_POLL ##1 s.st == ST_IDLE);
   c_buffer_full: cover property (s.count == ROW_FULL);
   c_refused: cover property ($rose(s.refused));
   c_load_done: cover property (s.cmd == CMD_LOAD && s.st == ST_ISSUE && s.step == STEP_LOAD_END);
endmodule

// ### testbench/fsps_dev_model.sv
`timescale 1ns/1ns
// ****************************************
// Flash controller and array model
// ****************************************
module fsps_dev_model
   import fsps_pkg::*;
#(
   parameter int ROW_WORDS = 4,
   parameter int STALL_CYC = 20
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Scenario controls
   input wire logic slow,
   input wire logic inj_err,
   // Instruction port
   input wire logic dev_req,
   input wire fsps_pkg::fsps_op_t dev_op,
   input wire logic [15:0] dev_ea,
   input wire logic [15:0] dev_wdata,
   output logic dev_ack,
   output logic [15:0] dev_rdata,
   input wire logic interrupt_hold_off,
   // Observation
   output logic [7:0] erase_cnt,
   output logic [7:0] row_cnt,
   output logic [13:0] erased_page,
   output logic [23:0] row_addr,
   output logic [31:0] row_sum,
   output logic [7:0] hold_bad
);
   logic [15:0] ctrl;
   logic [7:0] page;
   logic [1:0] key_st;
   logic [23:0] erase_ea;
   logic [23:0] first;
   logic [15:0] low;
   logic [31:0] sum;
   logic [6:0] loaded;
   logic [7:0] run_cnt;
   logic [1:0] dly;
   logic [1:0] nop_due;
   // Inverse outside acks, so a stale read never looks valid
   assign dev_rdata = dev_ack ? ctrl : ~ctrl;
   // Instruction execution; start bit self-clears after the stall
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         {ctrl, page, key_st, erase_ea, first, low, sum, loaded, run_cnt, dly, dev_ack, nop_due} <= '0;
         {erase_cnt, row_cnt, erased_page, row_addr, row_sum, hold_bad} <= '0;
      end else begin
         dev_ack <= 1'b0;
         if (run_cnt != 8'h00) begin
            run_cnt <= run_cnt - 8'h01;
            if (run_cnt == 8'h01) ctrl[15] <= 1'b0;
         end
         if (dev_req && !dev_ack) begin
            if (slow && dly != 2'h3) dly <= dly + 2'h1;
            else begin
               dly <= 2'h0;
               dev_ack <= 1'b1;
            end
         end
         if (dev_req && dev_ack) begin
            key_st <= 2'h0;
            if (dev_op == OP_KEY && !interrupt_hold_off) hold_bad <= hold_bad + 8'h01;
            // Both instructions right after a start must be pauses
            if (nop_due != 2'h0) begin
               nop_due <= nop_due - 2'h1;
               if (dev_op != OP_NOP) hold_bad <= hold_bad + 8'h01;
            end
            if (dev_op == OP_WR_CTRL && dev_wdata[15]) nop_due <= 2'h2;
            case (dev_op)
               OP_KEY: key_st <= (dev_wdata == KEY_FIRST) ? 2'h1 :
                  ((dev_wdata == KEY_SECOND && key_st == 2'h1) ? 2'h2 : 2'h0);
               OP_WR_PAGE: page <= dev_wdata[7:0];
               OP_TBL_LOW: begin
                  erase_ea <= {page, dev_ea};
                  low <= dev_wdata;
                  if (loaded == 7'h00) first <= {page, dev_ea};
               end
               OP_TBL_HIGH: if (loaded < ROW_WORDS[6:0]) begin
                  loaded <= loaded + 7'h01;
                  sum <= sum + {8'h00, dev_wdata[7:0], low};
               end
               OP_WR_CTRL: if (!dev_wdata[15]) ctrl <= {1'b0, dev_wdata[14:0]};
               else if (key_st != 2'h2 || !dev_wdata[14] || inj_err || ctrl[15]) ctrl[13] <= 1'b1;
               else begin
                  ctrl[15] <= 1'b1;
                  run_cnt <= STALL_CYC[7:0];
                  loaded <= 7'h00;
                  sum <= 32'h0;
                  if (ctrl[6] && ctrl[3:0] == 4'h2) begin
                     erase_cnt <= erase_cnt + 8'h01;
                     erased_page <= erase_ea[23:10];
                  end else if (!ctrl[6] && ctrl[3:0] == 4'h1 && loaded == ROW_WORDS[6:0]
                     && first[23:10] == erased_page) begin
                     row_cnt <= row_cnt + 8'h01;
                     row_addr <= first;
                     row_sum <= sum;
                  end
               end
               default: ;
            endcase
         end
      end
   end
endmodule

// ### testbench/fsps_host_bench.sv
`timescale 1ns/1ns
module fsps_host_bench;
   import fsps_pkg::*;
   localparam int RW = 4;
   localparam int LIMIT = 20000;
   logic ref_clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr;
   logic dev_req, dev_ack, interrupt_hold_off, slow, inj_err, er;
   logic [7:0] paddr, erase_cnt, row_cnt, hold_bad;
   logic [31:0] pwdata, prdata, rd, esum, row_sum;
   logic [15:0] dev_ea, dev_wdata, dev_rdata;
   logic [13:0] erased_page;
   logic [23:0] row_addr;
   fsps_op_t dev_op;
   int miscompares, compares, cycles;
   // ****************************************
   // Clock, design and device model
   // ****************************************
   always #2 ref_clk = ~ref_clk;
   fsps_host #(.ROW_WORDS(RW)) fsps_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_req(dev_req), .dev_op(dev_op),
      .dev_ea(dev_ea), .dev_wdata(dev_wdata), .dev_ack(dev_ack), .dev_rdata(dev_rdata),
      .interrupt_hold_off(interrupt_hold_off));
   fsps_dev_model #(.ROW_WORDS(RW)) fsps_dev_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
      .inj_err(inj_err), .dev_req(dev_req), .dev_op(dev_op), .dev_ea(dev_ea), .dev_wdata(dev_wdata),
      .dev_ack(dev_ack), .dev_rdata(dev_rdata), .interrupt_hold_off(interrupt_hold_off),
      .erase_cnt(erase_cnt), .row_cnt(row_cnt), .erased_page(erased_page), .row_addr(row_addr),
      .row_sum(row_sum), .hold_bad(hold_bad));
   // ****************************************
   // Bus tasks and checks
   // ****************************************
   task wrap_up;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Request held until pready is seen high, released after that edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Polls status until busy drops; bounded so a stuck sequence still ends
   task idle;
      int n;
      n = 0;
      do begin
         apb(1'b0, OFS_STATUS, 32'h0);
         n++;
      end while (rd[ST_BUSY_BIT] !== 1'b0 && n < 300);
   endtask
   // Fills one row at base and programs it
   task row(input logic [23:0] base);
      wr(OFS_ADDR, {8'h00, base});
      esum = 32'h0;
      for (int i = 0; i < RW; i++) begin
         wr(OFS_DATA, {8'h00, 24'h5A0000 + base + 24'(i)});
         esum = esum + {8'h00, 24'h5A0000 + base + 24'(i)};
         wr(OFS_CMD, {30'h0, CMD_LOAD});
         idle;
      end
      rdchk(OFS_STATUS, 32'h8 | (RW << ST_COUNT_LSB));
      wr(OFS_CMD, {30'h0, CMD_ROW});
      idle;
      chk(rd & 32'h7F7, 32'h0);
      chk({8'h00, row_addr}, {8'h00, base});
      chk(row_sum, esum);
   endtask
   // Cuts a hang short
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         wrap_up;
      end
   end
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      {ref_clk, rst_n, psel, penable, pwrite, slow, inj_err} = '0;
      {paddr, pwdata, miscompares, compares, cycles} = '0;
      clk_en = 1'b1;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rdchk(OFS_STATUS, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      wr(OFS_ADDR, 32'hFF012345);
      rdchk(OFS_ADDR, 32'h00012345);
      $display("test map done");
      wr(OFS_ADDR, 32'h480);
      wr(OFS_CMD, {30'h0, CMD_ROW});
      rdchk(OFS_STATUS, 32'h4);
      wr(OFS_STATUS, 32'h4);
      rdchk(OFS_STATUS, 32'h0);
      $display("test early row done");
      wr(OFS_ADDR, 32'h410);
      wr(OFS_CMD, {30'h0, CMD_ERASE});
      idle;
      chk(rd, 32'h8);
      chk({24'h0, erase_cnt}, 32'h1);
      chk({18'h0, erased_page}, 32'h1);
      $display("test erase done");
      row(24'h000480);
      chk({24'h0, row_cnt}, 32'h1);
      slow <= 1'b1;
      row(24'h000500);
      chk({24'h0, row_cnt}, 32'h2);
      wr(OFS_ADDR, 32'h580);
      for (int i = 0; i <= RW; i++) begin
         wr(OFS_CMD, {30'h0, CMD_LOAD});
         idle;
      end
      rdchk(OFS_STATUS, 32'hC | (RW << ST_COUNT_LSB));
      $display("test rows done");
      wr(OFS_ADDR, 32'h410);
      wr(OFS_CMD, {30'h0, CMD_ERASE});
      wr(OFS_ADDR, 32'h800);
      idle;
      chk(rd & 32'h4, 32'h4);
      rdchk(OFS_ADDR, 32'h410);
      chk({24'h0, erase_cnt}, 32'h2);
      wr(OFS_STATUS, 32'h6);
      $display("test busy done");
      inj_err <= 1'b1;
      wr(OFS_CMD, {30'h0, CMD_ERASE});
      idle;
      chk(rd & 32'hA, 32'h2);
      chk({24'h0, erase_cnt}, 32'h2);
      chk({24'h0, hold_bad}, 32'h0);
      $display("test bad unlock done");
      wrap_up;
   end
endmodule
